/* hdl/quad_rate_burst_sram_port.sv */
// four-word burst sram port with separate read and write data buses
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - address, requests on true edge; data both edges
// - every transaction moves four words
// - address ignored without a request
// - read request starts burst, next edge ignored
// - write request starts burst, next edge ignored
// - low lane select stores only its lane
// - data buses eighteen bits, lanes from zero
// - memory holds 1,048,576 words
// - output clocks tied high select input reference
// - read words one, three on complement edge; write words two, four
// - echo clocks run freely, aligned to data
// - read bus driven only for accepted reads
// - reads and writes overlap independently
// - low loop-bypass input bypasses delay loop
// - unused balls observable as applied level
// - burst address steps +0 to +3
// - read wins when both requested together
// - second back-to-back same request is ignored
// - read words from t+1 complement to t+3
module quad_rate_burst_sram_port (
  // system clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // input clock (true edge rising, complement edge falling)
  input wire logic i_link_clk,
  // requests and address
  input wire logic i_read_req_n,
  input wire logic i_write_req_n,
  input wire logic [burst_sram_pkg::BURST_ADDR_W-1:0] i_addr,
  // write port
  input wire logic [burst_sram_pkg::DATA_W-1:0] i_write_data_in,
  input wire logic [burst_sram_pkg::LANE_N-1:0] i_byte_write_select_n,
  // output clock pair and straps
  input wire logic i_out_clk_pos,
  input wire logic i_out_clk_neg,
  input wire logic i_dll_off_n,
  input wire logic [burst_sram_pkg::NC_W-1:0] i_nc_level,
  // read port
  output logic [burst_sram_pkg::DATA_W-1:0] o_read_data_out,
  output logic o_read_data_oe,
  output logic o_echo_timing_pos,
  output logic o_echo_timing_neg,
  // status
  output logic o_out_ref_is_input,
  output logic o_dll_bypassed,
  output logic [burst_sram_pkg::NC_W-1:0] o_nc_observe,
  output logic o_read_seen,
  output logic o_write_seen
);
  localparam int DW = burst_sram_pkg::DATA_W;
  localparam int AW = burst_sram_pkg::BURST_ADDR_W;

  function automatic logic [DW-1:0] lane_merge(
    input logic [DW-1:0] old_w,
    input logic [DW-1:0] new_w,
    input logic [burst_sram_pkg::LANE_N-1:0] sel_n
  );
    logic [DW-1:0] res;
    res = old_w;
    for (int l = 0; l < burst_sram_pkg::LANE_N; l++)
      if (!sel_n[l])
        res[l*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W] =
          new_w[l*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W];
    return res;
  endfunction : lane_merge

  // reset release, one copy per domain
  logic [burst_sram_pkg::RST_SYNC_N-1:0] rst_sync_r;
  logic [burst_sram_pkg::RST_SYNC_N-1:0] lrst_sync_r;
  logic rst_n;
  logic lrst_n;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      rst_sync_r <= '0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  always_ff @(posedge i_link_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      lrst_sync_r <= '0;
    else
      lrst_sync_r <= {lrst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];
  assign lrst_n = lrst_sync_r[1];

  // request acceptance
  logic rd_block_r;
  logic wr_block_r;
  logic rd_go;
  logic wr_go;
  logic [AW-1:0] rd_base_r;
  logic [AW-1:0] wr_base_r;
  assign rd_go = !i_read_req_n && !rd_block_r;
  assign wr_go = !i_write_req_n && !wr_block_r && !rd_go;

  always_ff @(posedge i_link_clk or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      rd_block_r <= 1'b0;
      wr_block_r <= 1'b0;
    end
    else
    begin
      rd_block_r <= rd_go;
      wr_block_r <= wr_go;
    end
  end

  always_ff @(posedge i_link_clk or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      rd_base_r <= burst_sram_pkg::ADDR_RST;
      wr_base_r <= burst_sram_pkg::ADDR_RST;
    end
    else
    begin
      if (rd_go)
        rd_base_r <= i_addr;
      if (wr_go)
        wr_base_r <= i_addr;
    end
  end

  // storage
  logic [DW-1:0] mem [0:burst_sram_pkg::MEM_DEPTH-1];

  // write engine, independent of the read side once a write is accepted
  burst_sram_pkg::wr_state_t wr_state_r;
  logic neg_pend_r;
  logic [burst_sram_pkg::WORD_ADDR_W-1:0] neg_addr_r;
  logic pos_wr;
  logic [burst_sram_pkg::WORD_ADDR_W-1:0] pos_addr;
  write_half_if half ();

  write_half_capture u_half (
    .i_link_clk(i_link_clk),
    .i_lrst_n(lrst_n),
    .i_data(i_write_data_in),
    .i_sel_n(i_byte_write_select_n),
    .half(half.cap)
  );

  assign pos_wr = (wr_state_r == burst_sram_pkg::WR_FIRST) ||
                  (wr_state_r == burst_sram_pkg::WR_SECOND);
  assign pos_addr = {wr_base_r, (wr_state_r == burst_sram_pkg::WR_FIRST) ?
                     burst_sram_pkg::BURST_OFS0 : burst_sram_pkg::BURST_OFS2};

  always_ff @(posedge i_link_clk or negedge lrst_n)
  begin
    if (!lrst_n)
      wr_state_r <= burst_sram_pkg::WR_IDLE;
    else
    begin
      case (wr_state_r)
        burst_sram_pkg::WR_IDLE:
          if (wr_go)
            wr_state_r <= burst_sram_pkg::WR_FIRST;
        burst_sram_pkg::WR_FIRST:
          wr_state_r <= burst_sram_pkg::WR_SECOND;
        burst_sram_pkg::WR_SECOND:
          wr_state_r <= wr_go ? burst_sram_pkg::WR_FIRST :
                        burst_sram_pkg::WR_IDLE;
        default:
          wr_state_r <= burst_sram_pkg::WR_IDLE;
      endcase
    end
  end

  // complement-edge word lands at the next true edge
  always_ff @(posedge i_link_clk or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      neg_pend_r <= 1'b0;
      neg_addr_r <= burst_sram_pkg::WORD_ADDR_RST;
    end
    else
    begin
      neg_pend_r <= pos_wr;
      neg_addr_r <= {wr_base_r, (wr_state_r == burst_sram_pkg::WR_FIRST) ?
                     burst_sram_pkg::BURST_OFS1 :
                     burst_sram_pkg::BURST_OFS3};
    end
  end

  always_ff @(posedge i_link_clk)
  begin
    if (neg_pend_r)
      mem[neg_addr_r] <= lane_merge(mem[neg_addr_r], half.data,
                                    half.sel_n);
    if (pos_wr)
      mem[pos_addr] <= lane_merge(mem[pos_addr], i_write_data_in,
                                  i_byte_write_select_n);
  end

  // read engine
  logic [2:0] rd_pipe_r;
  logic [DW-1:0] rd_buf_r [0:burst_sram_pkg::BURST_LEN-1];
  logic [DW-1:0] q_pos_r;
  logic [DW-1:0] q_neg_r;
  logic oe_pos_r;
  logic oe_neg_r;

  always_ff @(posedge i_link_clk or negedge lrst_n)
  begin
    if (!lrst_n)
      rd_pipe_r <= 3'h0;
    else
      rd_pipe_r <= {rd_pipe_r[1:0], rd_go};
  end

  always_ff @(posedge i_link_clk or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      for (int i = 0; i < burst_sram_pkg::BURST_LEN; i++)
        rd_buf_r[i] <= burst_sram_pkg::DATA_RST;
    end
    else if (rd_pipe_r[0])
    begin
      for (int i = 0; i < burst_sram_pkg::BURST_LEN; i++)
        rd_buf_r[i] <= mem[{rd_base_r, 2'(i)}];
    end
  end

  // second and fourth words on the true edge
  always_ff @(posedge i_link_clk or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      q_pos_r <= burst_sram_pkg::DATA_RST;
      oe_pos_r <= 1'b0;
    end
    else if (rd_pipe_r[1])
    begin
      q_pos_r <= rd_buf_r[1];
      oe_pos_r <= 1'b1;
    end
    else if (rd_pipe_r[2])
    begin
      q_pos_r <= rd_buf_r[3];
      oe_pos_r <= 1'b1;
    end
    else
      oe_pos_r <= 1'b0;
  end

  // first and third words on the complement edge
  always_ff @(negedge i_link_clk or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      q_neg_r <= burst_sram_pkg::DATA_RST;
      oe_neg_r <= 1'b0;
    end
    else if (rd_pipe_r[1])
    begin
      q_neg_r <= rd_buf_r[0];
      oe_neg_r <= 1'b1;
    end
    else if (rd_pipe_r[2])
    begin
      q_neg_r <= rd_buf_r[2];
      oe_neg_r <= 1'b1;
    end
    else
      oe_neg_r <= 1'b0;
  end

  // each half period shows the flop of the edge that opened it
  assign o_read_data_out = i_link_clk ? q_pos_r : q_neg_r;
  assign o_read_data_oe = i_link_clk ? oe_pos_r : oe_neg_r;
  assign o_echo_timing_pos = i_link_clk;
  assign o_echo_timing_neg = !i_link_clk;

  // output clock pair held high means input clocks are the reference
  logic [1:0] out_clk_lvl;
  logic out_ref_r;
  pin_sync #(.W(2), .RST_VAL(burst_sram_pkg::OUT_CLK_SYNC_RST)) u_oclk (
    .i_clk(i_link_clk),
    .i_rst_n(lrst_n),
    .i_async({i_out_clk_neg, i_out_clk_pos}),
    .o_level(out_clk_lvl)
  );
  always_ff @(posedge i_link_clk or negedge lrst_n)
  begin
    if (!lrst_n)
      out_ref_r <= 1'b0;
    else
      out_ref_r <= &out_clk_lvl;
  end
  assign o_out_ref_is_input = out_ref_r;

  // activity toggles cross to the system clock
  logic rd_tgl_r;
  logic wr_tgl_r;
  always_ff @(posedge i_link_clk or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      rd_tgl_r <= 1'b0;
      wr_tgl_r <= 1'b0;
    end
    else
    begin
      rd_tgl_r <= rd_tgl_r ^ rd_go;
      wr_tgl_r <= wr_tgl_r ^ wr_go;
    end
  end

  logic [burst_sram_pkg::NC_W+2:0] sys_lvl;
  logic [1:0] tgl_prev_r;
  logic rd_seen_r;
  logic wr_seen_r;
  logic dll_byp_r;
  logic [burst_sram_pkg::NC_W-1:0] nc_r;
  pin_sync #(.W(burst_sram_pkg::NC_W + 3),
             .RST_VAL(burst_sram_pkg::SYS_SYNC_RST)) u_sys (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_async({i_nc_level, i_dll_off_n, wr_tgl_r, rd_tgl_r}),
    .o_level(sys_lvl)
  );
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tgl_prev_r <= 2'h0;
      rd_seen_r <= 1'b0;
      wr_seen_r <= 1'b0;
      dll_byp_r <= 1'b0;
      nc_r <= '0;
    end
    else
    begin
      tgl_prev_r <= sys_lvl[1:0];
      rd_seen_r <= sys_lvl[0] ^ tgl_prev_r[0];
      wr_seen_r <= sys_lvl[1] ^ tgl_prev_r[1];
      dll_byp_r <= !sys_lvl[2];
      nc_r <= sys_lvl[burst_sram_pkg::NC_W+2:3];
    end
  end
  assign o_read_seen = rd_seen_r;
  assign o_write_seen = wr_seen_r;
  assign o_dll_bypassed = dll_byp_r;
  assign o_nc_observe = nc_r;

  // checks on the link domain
  a_read_next_ignored: assert property (
    @(posedge i_link_clk) disable iff (!lrst_n) rd_go |=> !rd_go)
    else $error("read accepted on two consecutive true edges");
  a_write_next_ignored: assert property (
    @(posedge i_link_clk) disable iff (!lrst_n) wr_go |=> !wr_go)
    else $error("write accepted on two consecutive true edges");
  a_read_has_priority: assert property (
    @(posedge i_link_clk) disable iff (!lrst_n)
    (!i_read_req_n && !i_write_req_n && !rd_block_r) |-> rd_go && !wr_go)
    else $error("write not yielding to read on the same edge");
  a_address_held: assert property (
    @(posedge i_link_clk) disable iff (!lrst_n)
    (!rd_go && !wr_go) |=> $stable(rd_base_r) && $stable(wr_base_r))
    else $error("address latched without a request");
  a_read_launch_time: assert property (
    @(posedge i_link_clk) disable iff (!lrst_n)
    rd_go |-> ##3 (oe_pos_r && q_pos_r == rd_buf_r[1]) ##1 oe_pos_r)
    else $error("true-edge read words not launched at t+2 and t+3");
  a_read_oe_cause: assert property (
    @(posedge i_link_clk) disable iff (!lrst_n)
    oe_pos_r |-> $past(rd_go, 3) || $past(rd_go, 4))
    else $error("read bus driven without an accepted read");
  a_read_bus_idle: assert property (
    @(posedge i_link_clk) disable iff (!lrst_n)
    (!rd_pipe_r[1] && !rd_pipe_r[2]) |=> !oe_pos_r)
    else $error("read bus still driven after the burst");
  a_write_burst_seq: assert property (
    @(posedge i_link_clk) disable iff (!lrst_n)
    wr_go |=> wr_state_r == burst_sram_pkg::WR_FIRST
      ##1 wr_state_r == burst_sram_pkg::WR_SECOND
      ##1 (neg_pend_r && neg_addr_r[1:0] == burst_sram_pkg::BURST_OFS3))
    else $error("write burst does not step through four words");
  a_lane_masked: assert property (
    @(posedge i_link_clk) disable iff (!lrst_n)
    (wr_state_r == burst_sram_pkg::WR_FIRST && &i_byte_write_select_n)
    |=> mem[$past(pos_addr)] == $past(mem[pos_addr]))
    else $error("deselected lanes were written");
endmodule : quad_rate_burst_sram_port
`default_nettype wire

/* hdl/burst_sram_pkg.sv */
// constants and types shared by the burst sram port
package burst_sram_pkg;
  localparam int DATA_W = 18;
  localparam int LANE_N = 2;
  localparam int LANE_W = 9;
  localparam int WORD_ADDR_W = 20;
  localparam int BURST_ADDR_W = 18;
  localparam int MEM_DEPTH = 1048576;
  localparam int BURST_LEN = 4;
  localparam int NC_W = 4;
  localparam int RST_SYNC_N = 2;
  localparam logic [1:0] BURST_OFS0 = 2'h0;
  localparam logic [1:0] BURST_OFS1 = 2'h1;
  localparam logic [1:0] BURST_OFS2 = 2'h2;
  localparam logic [1:0] BURST_OFS3 = 2'h3;
  localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
  localparam logic [BURST_ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [WORD_ADDR_W-1:0] WORD_ADDR_RST = 20'h00000;
  localparam logic [LANE_N-1:0] SEL_NONE_N = 2'h3;
  localparam logic [1:0] OUT_CLK_SYNC_RST = 2'h0;
  localparam logic [NC_W+2:0] SYS_SYNC_RST = 7'h04;
  typedef enum {WR_IDLE, WR_FIRST, WR_SECOND} wr_state_t;
endpackage : burst_sram_pkg

/* hdl/write_half_if.sv */
// write word and lane selects taken on the complement input clock edge
`timescale 1ns/1ps
`default_nettype none
interface write_half_if;
  logic [burst_sram_pkg::DATA_W-1:0] data;
  logic [burst_sram_pkg::LANE_N-1:0] sel_n;
  modport cap (output data, output sel_n);
  modport use_side (input data, input sel_n);
endinterface : write_half_if
`default_nettype wire

/* hdl/pin_sync.sv */
// three-stage synchroniser, output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // asynchronous inputs
  input wire logic [W-1:0] i_async,
  // filtered levels
  output logic [W-1:0] o_level
);
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic lvl_r;
      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          s1_r <= RST_VAL[g];
          s2_r <= RST_VAL[g];
          s3_r <= RST_VAL[g];
          lvl_r <= RST_VAL[g];
        end
        else
        begin
          s1_r <= i_async[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r)
            lvl_r <= s3_r;
        end
      end
      assign o_level[g] = lvl_r;
    end
  endgenerate
endmodule : pin_sync
`default_nettype wire

/* hdl/write_half_capture.sv */
// captures write data and lane selects on each complement input clock edge
`timescale 1ns/1ps
`default_nettype none
module write_half_capture (
  // link clock and reset
  input wire logic i_link_clk,
  input wire logic i_lrst_n,
  // write pins
  input wire logic [burst_sram_pkg::DATA_W-1:0] i_data,
  input wire logic [burst_sram_pkg::LANE_N-1:0] i_sel_n,
  // captured half word
  write_half_if.cap half
);
  always_ff @(negedge i_link_clk or negedge i_lrst_n)
  begin
    if (!i_lrst_n)
    begin
      half.data <= burst_sram_pkg::DATA_RST;
      half.sel_n <= burst_sram_pkg::SEL_NONE_N;
    end
    else
    begin
      half.data <= i_data;
      half.sel_n <= i_sel_n;
    end
  end
endmodule : write_half_capture
`default_nettype wire

/* testbench/burst_ctl_model.sv */
// controller model driving requests, address and write data
`timescale 1ns/1ps
`default_nettype none
module burst_ctl_model (
  // link clock
  input wire logic i_link_clk,
  // requests and write port
  output logic o_read_req_n,
  output logic o_write_req_n,
  output logic [burst_sram_pkg::BURST_ADDR_W-1:0] o_addr,
  output logic [burst_sram_pkg::DATA_W-1:0] o_data,
  output logic [burst_sram_pkg::LANE_N-1:0] o_sel_n,
  // output clock pair
  output logic o_out_clk_pos,
  output logic o_out_clk_neg
);
  typedef logic [burst_sram_pkg::DATA_W-1:0] word_t;
  initial
  begin
    o_read_req_n = 1'b1;
    o_write_req_n = 1'b1;
    o_addr = 18'h15555;
    o_data = 18'h2AAAA;
    o_sel_n = 2'h0;
    o_out_clk_pos = 1'b0;
    o_out_clk_neg = 1'b0;
  end
  // tied high before traffic, never toggled again
  task automatic tie_out_clks();
    @(posedge i_link_clk);
    #1;
    o_out_clk_pos = 1'b1;
    o_out_clk_neg = 1'b1;
  endtask : tie_out_clks
  // twice holds the request over a second edge on purpose
  task automatic issue_read(input logic [17:0] a, input bit twice);
    @(posedge i_link_clk);
    #1;
    o_read_req_n = 1'b0;
    o_addr = a;
    @(posedge i_link_clk);
    #1;
    o_read_req_n = !twice;
    o_addr = ~a;
    if (twice)
    begin
      @(posedge i_link_clk);
      #1;
      o_read_req_n = 1'b1;
    end
  endtask : issue_read
  task automatic issue_write(input logic [17:0] a, input word_t w [4],
    input logic [1:0] s [4], input bit twice, input bit both);
    @(posedge i_link_clk);
    #1;
    o_write_req_n = 1'b0;
    o_addr = a;
    if (both)
      o_read_req_n = 1'b0;
    @(posedge i_link_clk);
    #1;
    o_write_req_n = !twice;
    if (both)
      o_read_req_n = 1'b1;
    if (twice)
      o_addr = ~a;
    o_data = w[0];
    o_sel_n = s[0];
    @(posedge i_link_clk);
    #1;
    o_write_req_n = 1'b1;
    o_data = w[1];
    o_sel_n = s[1];
    @(negedge i_link_clk);
    #1;
    o_data = w[2];
    o_sel_n = s[2];
    @(posedge i_link_clk);
    #1;
    o_data = w[3];
    o_sel_n = s[3];
    @(negedge i_link_clk);
    #1;
    // no request now: selects and address left hostile
    o_data = ~w[3];
    o_sel_n = 2'h0;
    o_addr = ~a;
  endtask : issue_write
endmodule : burst_ctl_model
`default_nettype wire

/* testbench/quad_rate_burst_sram_port_tb.sv */
// self-checking bench for the burst sram port
`timescale 1ns/1ps
`default_nettype none
module quad_rate_burst_sram_port_tb;
  typedef logic [burst_sram_pkg::DATA_W-1:0] word_t;
  typedef logic [burst_sram_pkg::BURST_ADDR_W-1:0] baddr_t;
  typedef logic [burst_sram_pkg::LANE_N-1:0] sel_t;
  localparam int LW = burst_sram_pkg::LANE_W;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic nrst = 1'b0;
  logic dll_off_n = 1'b1;
  logic [burst_sram_pkg::NC_W-1:0] nc_level = 4'h0;
  logic rreq_n, wreq_n, oc_pos, oc_neg;
  baddr_t addr;
  word_t wdata, rdata;
  sel_t sel_n;
  logic rd_oe, echo_pos, echo_neg, ref_in, dll_byp, rd_seen, wr_seen;
  logic [burst_sram_pkg::NC_W-1:0] nc_obs;
  int err_count = 0;
  int samples_checked = 0;
  int rd_cnt = 0;
  int wr_cnt = 0;
  word_t ref_mem [int];
  sel_t all_on [4] = '{default: 2'h0};
  always #25 clk = ~clk;
  initial
  begin
    #2.3;
    forever #6 link_clk = ~link_clk;
  end
  always @(posedge clk)
  begin
    rd_cnt <= rd_cnt + (rd_seen === 1'b1);
    wr_cnt <= wr_cnt + (wr_seen === 1'b1);
  end
  burst_ctl_model ctl_u (
    .i_link_clk(link_clk), .o_read_req_n(rreq_n), .o_write_req_n(wreq_n),
    .o_addr(addr), .o_data(wdata), .o_sel_n(sel_n),
    .o_out_clk_pos(oc_pos), .o_out_clk_neg(oc_neg)
  );
  quad_rate_burst_sram_port dut_u (
    .i_clk(clk), .i_nrst(nrst), .i_link_clk(link_clk),
    .i_read_req_n(rreq_n), .i_write_req_n(wreq_n), .i_addr(addr),
    .i_write_data_in(wdata), .i_byte_write_select_n(sel_n),
    .i_out_clk_pos(oc_pos), .i_out_clk_neg(oc_neg),
    .i_dll_off_n(dll_off_n), .i_nc_level(nc_level),
    .o_read_data_out(rdata), .o_read_data_oe(rd_oe),
    .o_echo_timing_pos(echo_pos), .o_echo_timing_neg(echo_neg),
    .o_out_ref_is_input(ref_in), .o_dll_bypassed(dll_byp),
    .o_nc_observe(nc_obs), .o_read_seen(rd_seen), .o_write_seen(wr_seen)
  );
  task automatic chk(input string n, input word_t e, input word_t g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  `define CHK(n, e, g) chk(n, word_t'(e), word_t'(g))
  task automatic end_of_test();
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  function automatic word_t pat(input baddr_t a, input int i, input word_t s);
    return word_t'({a, i[1:0]}) ^ s;
  endfunction : pat
  // both raises a read on the same edge, so the write must be dropped
  task automatic wr(input baddr_t a, input word_t s, input sel_t m [4],
    input bit twice, input bit both);
    word_t w [4];
    int k;
    for (int i = 0; i < 4; i++)
      w[i] = pat(a, i, s);
    ctl_u.issue_write(a, w, m, twice, both);
    if (!both)
      for (int i = 0; i < 4; i++)
      begin
        k = int'({a, i[1:0]});
        for (int l = 0; l < 2; l++)
          if (!m[i][l])
            ref_mem[k][l*LW +: LW] = w[i][l*LW +: LW];
      end
  endtask : wr
  task automatic rd_capture(input baddr_t a);
    word_t e [4];
    for (int i = 0; i < 4; i++)
      e[i] = ref_mem[int'({a, i[1:0]})];
    @(posedge link_clk iff rreq_n === 1'b0);
    @(posedge link_clk);
    #3;
    `CHK("oe before word0", 1'b0, rd_oe);
    for (int i = 0; i < 4; i++)
    begin
      if (i[0])
        @(posedge link_clk);
      else
        @(negedge link_clk);
      #3;
      `CHK("oe during burst", 1'b1, rd_oe);
      `CHK("read word", e[i], rdata);
    end
    @(negedge link_clk);
    #3;
    `CHK("oe after burst", 1'b0, rd_oe);
    `CHK("echo pair", !echo_neg, echo_pos);
  endtask : rd_capture
  task automatic rd(input baddr_t a, input bit twice);
    fork
      ctl_u.issue_read(a, twice);
      rd_capture(a);
    join
  endtask : rd
  task automatic s_status();
    `CHK("ref untied", 1'b0, ref_in);
    ctl_u.tie_out_clks();
    @(posedge clk);
    #1;
    dll_off_n = 1'b0;
    nc_level = 4'hA;
    repeat (10) @(posedge clk);
    #2;
    `CHK("ref tied", 1'b1, ref_in);
    `CHK("dll bypass", 1'b1, dll_byp);
    `CHK("nc level", 4'hA, nc_obs);
    `CHK("echo idle", link_clk, echo_pos);
    dll_off_n = 1'b1;
    nc_level = 4'h5;
    repeat (10) @(posedge clk);
    #2;
    `CHK("dll normal", 1'b0, dll_byp);
    `CHK("nc level", 4'h5, nc_obs);
    `CHK("echo idle", !link_clk, echo_neg);
  endtask : s_status
  task automatic s_basic();
    baddr_t al [3] = '{18'h00000, 18'h3FFFF, 18'h12345};
    for (int i = 0; i < 3; i++)
      wr(al[i], 18'h2D2D2, all_on, 1'b0, 1'b0);
    for (int i = 0; i < 3; i++)
      rd(al[i], 1'b0);
  endtask : s_basic
  task automatic s_lanes();
    wr(18'h00ABC, 18'h3FFFF, all_on, 1'b0, 1'b0);
    wr(18'h00ABC, 18'h0F0F0, '{2'h3, 2'h2, 2'h1, 2'h0}, 1'b0, 1'b0);
    rd(18'h00ABC, 1'b0);
  endtask : s_lanes
  task automatic s_refuse();
    wr(~18'h01111, 18'h11111, all_on, 1'b0, 1'b0);
    wr(18'h01111, 18'h22222, all_on, 1'b1, 1'b0);
    rd(~18'h01111, 1'b0);
    rd(18'h01111, 1'b1);
  endtask : s_refuse
  task automatic s_precedence();
    wr(18'h02222, 18'h33333, all_on, 1'b0, 1'b0);
    fork
      wr(18'h02222, 18'h04444, all_on, 1'b0, 1'b1);
      rd_capture(18'h02222);
    join
    rd(18'h02222, 1'b0);
  endtask : s_precedence
  task automatic s_concurrent();
    fork
      wr(18'h03333, 18'h15A5A, all_on, 1'b0, 1'b0);
      begin
        @(posedge link_clk);
        rd(18'h00ABC, 1'b0);
      end
    join
    rd(18'h03333, 1'b0);
  endtask : s_concurrent
  initial
  begin
    repeat (10) @(posedge clk);
    `CHK("oe in reset", 1'b0, rd_oe);
    repeat (6) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (4) @(posedge clk);
    s_status();
    s_basic();
    s_lanes();
    s_refuse();
    s_precedence();
    s_concurrent();
    repeat (10) @(posedge clk);
    `CHK("activity seen", 1'b1, rd_cnt > 0 && wr_cnt > 0);
    end_of_test();
  end
  initial
  begin
    #200000;
    err_count++;
    end_of_test();
  end
endmodule : quad_rate_burst_sram_port_tb
`default_nettype wire
